// *** logic/test_router_pkg.sv ***
// constants for the test-signal router and pseudo-random pattern block
// Contract
// - bit select picks probe bit for link pin
// - swap bit reorders probe bus on pins
// - prbs9 bit arms 9-bit sequence source
// - prbs15 bit arms 15-bit sequence source
// - pattern starts only on send command
// - group select picks internal probe group
// - extra uart lines gated by enable bit
// - per-pin drive enable bits 6..1
// - spi or uart-extra limits pins 1..4
// - reset values 80h drive, 00h others
// - selected probe bus readable as status
`default_nettype none
package test_router_pkg;
  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_RESERVED   = 6'h30;
  localparam logic [5:0] IDX_BIT_ROUTE  = 6'h31;
  localparam logic [5:0] IDX_GROUP_CTRL = 6'h32;
  localparam logic [5:0] IDX_PIN_DRIVE  = 6'h33;
  localparam logic [5:0] IDX_PROBE_STAT = 6'h35;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_SEL_W      = 3;
  localparam int         GROUP_SEL_W    = 5;
  localparam int         NUM_GROUPS     = 32;
  localparam int         BUS_W          = 8;
  localparam int         SWAP_BIT       = 7;
  localparam int         PRBS9_BIT      = 6;
  localparam int         PRBS15_BIT     = 5;
  localparam int         UART_EN_BIT    = 7;
  localparam int         PIN_LO         = 1;
  localparam int         PIN_HI         = 6;
  localparam int         PIN_LIMIT      = 4;
  localparam logic [7:0] BIT_ROUTE_RST  = 8'h00;
  localparam logic [7:0] GROUP_CTRL_RST = 8'h00;
  localparam logic [7:0] PIN_DRIVE_RST  = 8'h80;
  localparam logic [7:0] BIT_ROUTE_MASK = 8'h07;
  localparam logic [7:0] PIN_DRIVE_MASK = 8'hFE;
  // ----------------------------------------------------------------
  // pseudo-random generator
  // ----------------------------------------------------------------
  localparam int          LFSR_W    = 15;
  localparam logic [14:0] LFSR_SEED = 15'h7FFF;
  localparam int          P9_TAP_A  = 8;
  localparam int          P9_TAP_B  = 4;
  localparam int          P15_TAP_A = 14;
  localparam int          P15_TAP_B = 13;
  typedef enum logic [1:0] {
    PAT_IDLE  = 2'b00,
    PAT_ARMED = 2'b01,
    PAT_RUN   = 2'b10
  } pat_state_t;
endpackage
`default_nettype wire

// *** logic/test_signal_router_prbs.sv ***
// test-signal router, probe pin drivers and pseudo-random pattern source
`default_nettype none
module test_signal_router_prbs
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // internal signal groups, group g in bits 8g+7..8g
  input  wire logic [255:0]           probe_groups,
  // host interface mode, from pins
  input  wire logic                   spi_mode_pin,
  input  wire logic                   uart_mode_pin,
  // uart auxiliary lines from the uart logic
  input  wire logic                   uart_aux_line_a_in,
  input  wire logic                   uart_aux_line_b_in,
  output logic                        uart_aux_line_a,
  output logic                        uart_aux_line_b,
  output logic                        uart_aux_oe,
  // test outputs
  output logic                        card_link_output_pin,
  output logic      [6:1]             probe_pins,
  output logic      [6:1]             probe_pins_oe,
  // pattern transmit
  input  wire logic                   send_cmd,
  input  wire logic                   tx_bit_strobe,
  output logic                        prbs_active,
  output logic                        prbs_data
);
  import test_router_pkg::*;

  // ----------------------------------------------------------------
  // mode pin synchronisers
  // ----------------------------------------------------------------
  logic             spi_meta_q;
  logic             spi_q;
  logic             uart_meta_q;
  logic             uart_q;
  // two stages; only the second is read by logic
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spi_meta_q  <= 1'b0;
      spi_q       <= 1'b0;
      uart_meta_q <= 1'b0;
      uart_q      <= 1'b0;
    end
    else
    begin
      spi_meta_q  <= spi_mode_pin;
      spi_q       <= spi_meta_q;
      uart_meta_q <= uart_mode_pin;
      uart_q      <= uart_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [5:0]       idx;
  logic             aligned;
  logic             mapped;
  logic             wr_lane0;
  assign idx      = paddr[7:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  // reserved slot is mapped but inert
  assign mapped   = aligned && ((idx == IDX_RESERVED) || (idx == IDX_BIT_ROUTE) ||
                    (idx == IDX_GROUP_CTRL) || (idx == IDX_PIN_DRIVE) ||
                    (idx == IDX_PROBE_STAT));
  assign wr_lane0 = psel && penable && pwrite && pstrb[0] && mapped;
  // zero wait state; data was fetched during setup
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0]       bit_route_q;
  logic [7:0]       group_ctrl_q;
  logic [7:0]       pin_drive_q;
  // reserved bits masked off at write time so they always read zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_route_q  <= BIT_ROUTE_RST;
      group_ctrl_q <= GROUP_CTRL_RST;
      pin_drive_q  <= PIN_DRIVE_RST;
    end
    else if (wr_lane0)
    begin
      if (idx == IDX_BIT_ROUTE)
        bit_route_q <= pwdata[7:0] & BIT_ROUTE_MASK;
      if (idx == IDX_GROUP_CTRL)
        group_ctrl_q <= pwdata[7:0];
      if (idx == IDX_PIN_DRIVE)
        pin_drive_q <= pwdata[7:0] & PIN_DRIVE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // probe bus selection
  // ----------------------------------------------------------------
  logic [GROUP_SEL_W-1:0] group_sel;
  logic [BIT_SEL_W-1:0]   bit_sel;
  logic [BUS_W-1:0]       probe_bus_d;
  logic [BUS_W-1:0]       probe_bus_q;
  assign group_sel   = group_ctrl_q[GROUP_SEL_W-1:0];
  assign bit_sel     = bit_route_q[BIT_SEL_W-1:0];
  assign probe_bus_d = probe_groups[group_sel*BUS_W +: BUS_W];
  // one flop stage keeps pin outputs glitch free
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      probe_bus_q <= '0;
    else
      probe_bus_q <= probe_bus_d;
  end

  // ----------------------------------------------------------------
  // apb read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [7:0]       rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (aligned)
    begin
      if (idx == IDX_BIT_ROUTE)
        rd_byte = bit_route_q;
      else if (idx == IDX_GROUP_CTRL)
        rd_byte = group_ctrl_q;
      else if (idx == IDX_PIN_DRIVE)
        rd_byte = pin_drive_q;
      else if (idx == IDX_PROBE_STAT)
        rd_byte = probe_bus_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= {24'h000000, rd_byte};
  end

  // ----------------------------------------------------------------
  // test pin outputs
  // ----------------------------------------------------------------
  logic [6:1]       pin_val_d;
  logic [6:1]       pin_oe_d;
  logic             uart_en;
  logic             pin_limited;
  assign uart_en     = pin_drive_q[UART_EN_BIT];
  // upper pins double as host interface lines in these modes
  assign pin_limited = spi_q || (uart_q && uart_en);
  always_comb
  begin
    pin_val_d = probe_bus_q[6:1];
    if (group_ctrl_q[SWAP_BIT])
      pin_val_d = {probe_bus_q[4], probe_bus_q[3], probe_bus_q[2],
                   probe_bus_q[6], probe_bus_q[5], probe_bus_q[0]};
  end

  genvar gp;
  generate
    for (gp = PIN_LO; gp <= PIN_HI; gp++)
    begin : g_pin
      assign pin_oe_d[gp] = pin_drive_q[gp] && !(pin_limited && (gp > PIN_LIMIT));
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      probe_pins           <= '0;
      probe_pins_oe        <= '0;
      card_link_output_pin <= 1'b0;
    end
    else
    begin
      probe_pins           <= pin_val_d;
      probe_pins_oe        <= pin_oe_d;
      card_link_output_pin <= probe_bus_q[bit_sel];
    end
  end

  // ----------------------------------------------------------------
  // uart auxiliary lines
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      uart_aux_line_a <= 1'b0;
      uart_aux_line_b <= 1'b0;
      uart_aux_oe     <= 1'b0;
    end
    else
    begin
      uart_aux_line_a <= uart_en && uart_aux_line_a_in;
      uart_aux_line_b <= uart_en && uart_aux_line_b_in;
      uart_aux_oe     <= uart_en && uart_q;
    end
  end

  // ----------------------------------------------------------------
  // pseudo-random pattern generator
  // ----------------------------------------------------------------
  logic             p9_en;
  logic             p15_en;
  logic             pat_en;
  logic             fb;
  pat_state_t       pat_q;
  logic [LFSR_W-1:0] lfsr_q;
  assign p9_en  = group_ctrl_q[PRBS9_BIT];
  assign p15_en = group_ctrl_q[PRBS15_BIT];
  assign pat_en = p9_en || p15_en;
  // both set: the shorter sequence wins
  assign fb     = p9_en ? (lfsr_q[P9_TAP_A] ^ lfsr_q[P9_TAP_B])
                        : (lfsr_q[P15_TAP_A] ^ lfsr_q[P15_TAP_B]);

  // enabling only arms; the host must have set up transmit first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pat_q <= PAT_IDLE;
    else if (!pat_en)
      pat_q <= PAT_IDLE;
    else
    begin
      unique case (pat_q)
        PAT_IDLE:  pat_q <= send_cmd ? PAT_RUN : PAT_ARMED;
        PAT_ARMED: pat_q <= send_cmd ? PAT_RUN : PAT_ARMED;
        PAT_RUN:   pat_q <= PAT_RUN;
        default:   pat_q <= PAT_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr_q    <= LFSR_SEED;
      prbs_data <= 1'b0;
    end
    else if (pat_q != PAT_RUN)
    begin
      lfsr_q    <= LFSR_SEED; // held at seed until the pattern runs
      prbs_data <= 1'b0;
    end
    else if (tx_bit_strobe)
    begin
      lfsr_q    <= {lfsr_q[LFSR_W-2:0], fb};
      prbs_data <= p9_en ? lfsr_q[P9_TAP_A] : lfsr_q[P15_TAP_A];
    end
  end

  assign prbs_active = (pat_q == PAT_RUN);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_link_bit_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    card_link_output_pin == $past(probe_bus_q[bit_sel]))
    else $error("link pin does not follow selected bit");

  a_swap_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(group_ctrl_q[SWAP_BIT]) |-> probe_pins[3] == $past(probe_bus_q[6]))
    else $error("swapped order wrong on pin 3");

  a_no_early_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(pat_q) != PAT_RUN) && !$past(send_cmd) |-> !prbs_active)
    else $error("pattern started without send");

  a_start_on_send: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pat_en && send_cmd ##1 pat_en |-> prbs_active)
    else $error("send did not start pattern");

  a_prbs9_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    prbs_active && tx_bit_strobe && p9_en ##1 prbs_active |->
      lfsr_q[0] == ($past(lfsr_q[P9_TAP_A]) ^ $past(lfsr_q[P9_TAP_B])))
    else $error("prbs9 feedback wrong");

  a_prbs15_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    prbs_active && tx_bit_strobe && !p9_en && p15_en ##1 prbs_active |->
      lfsr_q[0] == ($past(lfsr_q[P15_TAP_A]) ^ $past(lfsr_q[P15_TAP_B])))
    else $error("prbs15 feedback wrong");

  a_group_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
    probe_bus_q == $past(probe_groups[group_sel*BUS_W +: BUS_W]))
    else $error("probe bus not from selected group");

  a_uart_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(uart_en) |-> !uart_aux_line_a && !uart_aux_line_b && !uart_aux_oe)
    else $error("aux lines active while disabled");

  a_pin_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(pin_limited) |-> probe_pins_oe[6:5] == 2'b00)
    else $error("upper pins driven while limited");

  a_pin_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    probe_pins_oe[2:1] == $past(pin_drive_q[2:1]))
    else $error("pin drive enable mismatch");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bit_route_q & ~BIT_ROUTE_MASK) == 8'h00 && (pin_drive_q & ~PIN_DRIVE_MASK) == 8'h00)
    else $error("reserved bits not zero");
endmodule
`default_nettype wire

// *** testbench/probe_observer.sv ***
// test equipment model watching the parallel probe pins
`default_nettype none
module probe_observer
(
  // pins as the equipment sees them
  input  wire logic       ref_clk,
  input  wire logic [6:1] probe_pins,
  input  wire logic [6:1] probe_pins_oe,
  // level taken by the equipment
  output logic      [6:1] pin_view
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:1] last_q;
  // remember the last level seen on each pin
  always_ff @(posedge ref_clk)
    last_q <= pin_view;
  // no pull on the pins: a released pin toggles, so a stale level never passes
  assign pin_view = (probe_pins & probe_pins_oe) | (~last_q & ~probe_pins_oe);
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the test-signal router and pattern source
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import test_router_pkg::*;
  logic         ref_clk, rst_n, psel, penable, pwrite, send_cmd, tx_bit_strobe, err;
  logic         spi_mode_pin, uart_mode_pin, uart_aux_line_a_in, uart_aux_line_b_in;
  logic         pready, pslverr, uart_aux_line_a, uart_aux_line_b, uart_aux_oe;
  logic         card_link_output_pin, prbs_active, prbs_data;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rdata;
  logic [3:0]   pstrb;
  logic [255:0] probe_groups;
  logic [6:1]   probe_pins, probe_pins_oe, pin_view;
  logic [14:0]  lfsr;
  logic [7:0]   ctl [3];
  int           failures, compares, mreg[4];
  integer       seed;
  // ----------------------------------------------------------------
  // clock, design and far-side model
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  test_signal_router_prbs dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .probe_groups, .spi_mode_pin,
    .uart_mode_pin, .uart_aux_line_a_in, .uart_aux_line_b_in, .uart_aux_line_a,
    .uart_aux_line_b, .uart_aux_oe, .card_link_output_pin, .probe_pins, .probe_pins_oe,
    .send_cmd, .tx_bit_strobe, .prbs_active, .prbs_data);
  probe_observer observer (.ref_clk, .probe_pins, .probe_pins_oe, .pin_view);
  // ----------------------------------------------------------------
  // bus, compare and model tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the wait ends only on pready or the watchdog
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // write and keep the register model in step; reserved bits never stick
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
    chk({31'h0, err}, 32'h0);
    case (idx)
      IDX_BIT_ROUTE:  mreg[1] = d & 8'h07;
      IDX_GROUP_CTRL: mreg[2] = d;
      IDX_PIN_DRIVE:  mreg[3] = d & 8'hFE;
      default:        ;
    endcase
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdata, {24'h0, exp});
    chk({31'h0, err}, 32'h0);
  endtask
  // one-cycle pulse on send (1) or bit strobe (0), result looked at after it lands
  task automatic pulse(input logic snd);
    @(posedge ref_clk);
    if (snd)
      send_cmd <= 1'b1;
    else
      tx_bit_strobe <= 1'b1;
    @(posedge ref_clk);
    send_cmd      <= 1'b0;
    tx_bit_strobe <= 1'b0;
    #1;
  endtask
  function automatic logic [6:1] pin_map(input logic [7:0] b, input logic sw);
    return sw ? {b[4], b[3], b[2], b[6], b[5], b[0]} : b[6:1];
  endfunction
  // spi, or uart with its extra lines, leaves only pins 1..4
  function automatic logic [6:1] oe_exp();
    logic lim;
    lim = spi_mode_pin | (uart_mode_pin & mreg[3][7]);
    return mreg[3][6:1] & (lim ? 6'h0F : 6'h3F);
  endfunction
  // group select, status, pin order, drivers, link pin and uart lines
  task automatic probe_check(input int g, input logic sw);
    logic [7:0] b;
    logic       en;
    wr(IDX_GROUP_CTRL, {sw, 2'b00, 5'(g)});
    for (int w = 0; w < 8; w++)
      probe_groups[w*32 +: 32] <= $random(seed);
    uart_aux_line_a_in <= $random(seed);
    uart_aux_line_b_in <= $random(seed);
    repeat (4) @(posedge ref_clk);
    b  = probe_groups[g*8 +: 8];
    en = mreg[3][7];
    rd(IDX_PROBE_STAT, b);
    chk(probe_pins_oe, oe_exp());
    chk(probe_pins & oe_exp(), pin_map(b, sw) & oe_exp());
    chk(pin_view & oe_exp(), pin_map(b, sw) & oe_exp());
    chk({uart_aux_line_a, uart_aux_line_b, uart_aux_oe}, {uart_aux_line_a_in & en,
        uart_aux_line_b_in & en, uart_mode_pin & en});
    for (int k = 0; k < 8; k++)
    begin
      wr(IDX_BIT_ROUTE, 8'(k) | 8'hF8);
      repeat (2) @(posedge ref_clk);
      chk(card_link_output_pin, b[k]);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'hC9AE9E10;
    {psel, penable, pwrite, send_cmd, tx_bit_strobe} = '0;
    {spi_mode_pin, uart_mode_pin, uart_aux_line_a_in, uart_aux_line_b_in} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    probe_groups = '0;
    rst_n = 1'b0;
    failures = 0;
    compares = 0;
    mreg = '{0, 0, 0, 'h80};
    ctl = '{8'h40, 8'h20, 8'h60};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(IDX_RESERVED + 6'(i), 8'(mreg[i]));
    for (int i = 0; i < 4; i++)
      wr(IDX_RESERVED + 6'(i), 8'hFF);
    wr(IDX_PROBE_STAT, 8'hFF);
    for (int i = 0; i < 4; i++)
      rd(IDX_RESERVED + 6'(i), 8'(mreg[i]));
    // unmapped place answers with an error and zero data
    apb(1'b0, 6'h3F, 32'h0);
    chk({err, rdata[30:0]}, 32'h80000000);
    // a write with byte lane 0 off must leave the bit select alone
    pstrb <= 4'hE;
    apb(1'b1, IDX_BIT_ROUTE, 32'h00000005);
    pstrb <= 4'hF;
    rd(IDX_BIT_ROUTE, 8'(mreg[1]));
    for (int i = 0; i < 12; i++)
    begin
      {spi_mode_pin, uart_mode_pin} <= 2'(i % 3);
      wr(IDX_PIN_DRIVE, 8'($random(seed)));
      probe_check(($random(seed) & 31), i[0]);
    end
    // patterns: armed by the enable bit, started only by send
    for (int m = 0; m < 3; m++)
    begin
      wr(IDX_GROUP_CTRL, 8'h00);
      pulse(1'b1);
      chk(prbs_active, 1'b0);
      wr(IDX_GROUP_CTRL, ctl[m]);
      repeat (3) @(posedge ref_clk);
      chk(prbs_active, 1'b0);
      pulse(1'b1);
      chk(prbs_active, 1'b1);
      lfsr = 15'h7FFF;
      for (int n = 0; n < 40; n++)
      begin
        pulse(1'b0);
        chk(prbs_data, (m == 1) ? lfsr[14] : lfsr[8]);
        lfsr = (m == 1) ? {lfsr[13:0], lfsr[14] ^ lfsr[13]} : {lfsr[13:0], lfsr[8] ^ lfsr[4]};
      end
    end
    wr(IDX_GROUP_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk(prbs_active, 1'b0);
    complete_run();
  end
  // a hang counts as a mismatch and ends the run the usual way
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
